// ### design/sct_pkg.sv
// Operation
// - execute trap only when condition passes
// - executed trap enters supervisor mode
// - vector to fixed address, save status word
// - link register gets following word address
// - flag-setting return move restores status word
// - nested trap overwrites link and saved status
// - low 24 trap bits ignored by decode
// - trap occupies three fetch cycles
// - only control coprocessor fifteen register moves
// - other coprocessor instructions take undefined trap
// - internal coprocessor op traps undefined whenever condition passes
// - coprocessor load/store traps, no memory access
// - internal op decode uses bit 4, 27:24
// - internal op returns nothing, core never waits
// - core gives address, coprocessor moves data
// - transfer class 110 with P, U, L, W
// - move to r15 copies flags only
// - config access: one fetch, three internal cycles
package sct_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam int          REG_AW    = 8;
   localparam logic [7:0]  OFS_INSTR = 8'h00;
   localparam logic [7:0]  OFS_PSW   = 8'h04;
   localparam logic [7:0]  OFS_SPSR  = 8'h08;
   localparam logic [7:0]  OFS_LINK  = 8'h0c;
   localparam logic [7:0]  OFS_PC    = 8'h10;
   localparam logic [7:0]  OFS_XFER  = 8'h14;
   localparam logic [7:0]  OFS_CFG   = 8'h18;
   localparam logic [7:0]  OFS_STAT  = 8'h1c;
   localparam logic [7:0]  OFS_DEC   = 8'h20;
   // ----------------------------------------------------------------
   // reset values, vectors, modes
   // ----------------------------------------------------------------
   localparam logic [31:0] PSW_RST   = 32'h0000_0010;
   localparam logic [31:0] VEC_SOFT  = 32'h0000_0008;
   localparam logic [31:0] VEC_UNDEF = 32'h0000_0004;
   localparam logic [31:0] WORD_STEP = 32'h0000_0004;
   localparam logic [31:0] PC_READ_OFS = 32'h0000_000c;
   localparam logic [4:0]  MODE_SVC  = 5'h13;
   localparam logic [4:0]  MODE_UND  = 5'h1b;
   // ----------------------------------------------------------------
   // instruction fields
   // ----------------------------------------------------------------
   localparam int          COND_LSB  = 28;
   localparam int          CLS_LSB   = 24;
   localparam int          MODE_MSB  = 4;
   localparam int          CP_LSB    = 8;
   localparam int          RD_LSB    = 12;
   localparam int          BIT_MOVE  = 4;
   localparam int          BIT_LOAD  = 20;
   localparam logic [3:0]  CLS_SOFT  = 4'hf;
   localparam logic [3:0]  CLS_COP   = 4'he;
   localparam logic [2:0]  CLS_CMEM  = 3'h6;
   localparam logic [3:0]  CP_CTRL   = 4'hf;
   localparam logic [3:0]  REG_R15   = 4'hf;
   localparam logic [27:0] RET_CODE  = 28'h1b0_f00e;
   localparam logic [31:0] CMEM_MASK = 32'h01f0_00ff;
   // ----------------------------------------------------------------
   // timing and status
   // ----------------------------------------------------------------
   localparam logic [2:0]  SOFT_CYC  = 3'h3;
   localparam logic [2:0]  CFG_CYC   = 3'h4;
   localparam int          STAT_OUT  = 1;
   localparam logic [2:0]  OUT_NONE  = 3'h0;
   localparam logic [2:0]  OUT_SKIP  = 3'h1;
   localparam logic [2:0]  OUT_SOFT  = 3'h2;
   localparam logic [2:0]  OUT_UNDEF = 3'h3;
   localparam logic [2:0]  OUT_CFG   = 3'h4;
   localparam logic [2:0]  OUT_RET   = 3'h5;
   localparam logic [2:0]  OUT_OTHER = 3'h6;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_BUSY = 2'b10
   } sct_state_type;
endpackage : sct_pkg

// ### design/sct_top.sv
// The address map and the AHB-Lite interface to the registers were left to the implementer.
module sct_top
   import sct_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // ahb-lite slave
   input  wire logic              hsel,
   input  wire logic [ADDR_W-1:0] haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic [31:0]            hrdata,
   output logic                   hresp,
   // core events and state
   output logic                   soft_taken,
   output logic                   undef_taken,
   output logic                   busy,
   output logic [31:0]            cur_status
);

   // ----------------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------------
   if (ADDR_W < REG_AW) begin : g_bad_aw
      $error("sct_top: ADDR_W must be at least 8");
   end

   // ----------------------------------------------------------------
   // condition evaluation
   // ----------------------------------------------------------------
   function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
      logic n;
      logic z;
      logic cy;
      logic v;
      logic base;
      n = f[3];
      z = f[2];
      cy = f[1];
      v = f[0];
      case (c[3:1])
         3'h0: base = z;
         3'h1: base = cy;
         3'h2: base = n;
         3'h3: base = v;
         3'h4: base = cy & ~z;
         3'h5: base = (n == v);
         3'h6: base = ~z & (n == v);
         default: base = 1'b1;
      endcase
      // the never code fails rather than inverting always
      if (c[3:1] == 3'h7) begin
         cond_pass = ~c[0];
      end else begin
         cond_pass = base ^ c[0];
      end
   endfunction : cond_pass

   // ----------------------------------------------------------------
   // bus state
   // ----------------------------------------------------------------
   logic              dp_wr;
   logic              dp_rd;
   logic [7:0]        dp_addr;
   logic              next_dp_wr;
   logic              next_dp_rd;
   logic [7:0]        next_dp_addr;
   logic [31:0]       next_hrdata;
   logic              take;

   // ----------------------------------------------------------------
   // core state
   // ----------------------------------------------------------------
   sct_state_type     state;
   sct_state_type     next_state;
   logic [2:0]        cnt;
   logic [2:0]        next_cnt;
   logic [31:0]       pc;
   logic [31:0]       next_pc;
   logic [31:0]       psw;
   logic [31:0]       next_psw;
   logic [31:0]       spsr;
   logic [31:0]       next_spsr;
   logic [31:0]       link;
   logic [31:0]       next_link;
   logic [31:0]       xfer;
   logic [31:0]       next_xfer;
   logic [31:0]       cfg;
   logic [31:0]       next_cfg;
   logic [31:0]       dec;
   logic [31:0]       next_dec;
   logic [2:0]        outcome;
   logic [2:0]        next_outcome;
   logic              next_soft;
   logic              next_undef;

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   assign take      = hsel & htrans[1] & hready;
   // one wait state on reads keeps hrdata straight from a flop
   assign hreadyout = ~dp_rd;
   assign hresp     = 1'b0;

   always_comb begin
      next_dp_wr   = take & hwrite;
      next_dp_rd   = take & ~hwrite;
      next_dp_addr = take ? haddr[REG_AW-1:0] : dp_addr;
      next_hrdata  = hrdata;
      if (dp_rd) begin
         case (dp_addr)
            OFS_PSW:  next_hrdata = psw;
            OFS_SPSR: next_hrdata = spsr;
            OFS_LINK: next_hrdata = link;
            OFS_PC:   next_hrdata = pc;
            OFS_XFER: next_hrdata = xfer;
            OFS_CFG:  next_hrdata = cfg;
            OFS_STAT: next_hrdata = {28'h000_0000, outcome, busy};
            OFS_DEC:  next_hrdata = dec;
            default:  next_hrdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr   <= 1'b0;
         dp_rd   <= 1'b0;
         dp_addr <= 8'h00;
         hrdata  <= 32'h0000_0000;
      end else begin
         dp_wr   <= next_dp_wr;
         dp_rd   <= next_dp_rd;
         dp_addr <= next_dp_addr;
         hrdata  <= next_hrdata;
      end
   end

   // ----------------------------------------------------------------
   // instruction fields
   // ----------------------------------------------------------------
   // decoded straight from hwdata in the write data phase
   logic [3:0]        ins_cond;
   logic [3:0]        ins_class;
   logic [3:0]        ins_cp;
   logic [3:0]        ins_rd;
   assign ins_cond  = hwdata[COND_LSB+3:COND_LSB];
   assign ins_class = hwdata[CLS_LSB+3:CLS_LSB];
   assign ins_cp    = hwdata[CP_LSB+3:CP_LSB];
   assign ins_rd    = hwdata[RD_LSB+3:RD_LSB];

   // ----------------------------------------------------------------
   // decode and execute
   // ----------------------------------------------------------------
   assign busy       = (state == ST_BUSY);
   assign cur_status = psw;

   always_comb begin
      logic [31:0] ins;
      logic        do_undef;
      ins          = hwdata;
      do_undef     = 1'b0;
      next_state   = state;
      next_cnt     = cnt;
      next_pc      = pc;
      next_psw     = psw;
      next_spsr    = spsr;
      next_link    = link;
      next_xfer    = xfer;
      next_cfg     = cfg;
      next_dec     = dec;
      next_outcome = outcome;
      next_soft    = 1'b0;
      next_undef   = 1'b0;
      case (state)
         ST_BUSY: begin
            // writes during a multi-cycle instruction are dropped
            next_cnt = cnt - 3'h1;
            if (cnt == 3'h1) begin
               next_state = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (dp_wr) begin
               case (dp_addr)
                  OFS_PSW:  next_psw  = hwdata;
                  OFS_SPSR: next_spsr = hwdata;
                  OFS_LINK: next_link = hwdata;
                  OFS_PC:   next_pc   = hwdata;
                  OFS_XFER: next_xfer = hwdata;
                  OFS_CFG:  next_cfg  = hwdata;
                  OFS_INSTR: begin
                     next_pc = pc + WORD_STEP;
                     if (!cond_pass(ins_cond, psw[31:COND_LSB])) begin
                        next_outcome = OUT_SKIP;
                     end else if (ins_class == CLS_SOFT) begin
                        next_psw[MODE_MSB:0] = MODE_SVC;
                        next_spsr = psw;
                        next_pc   = VEC_SOFT;
                        next_link = pc + WORD_STEP;
                        next_soft = 1'b1;
                        next_outcome = OUT_SOFT;
                        next_state = ST_BUSY;
                        next_cnt   = SOFT_CYC - 3'h1;
                     end else if (ins_class == CLS_COP && !ins[BIT_MOVE]) begin
                        do_undef = 1'b1;
                     end else if (ins_class == CLS_COP) begin
                        if (ins_cp != CP_CTRL) begin
                           do_undef = 1'b1;
                        end else begin
                           next_outcome = OUT_CFG;
                           next_state = ST_BUSY;
                           next_cnt   = CFG_CYC - 3'h1;
                           if (ins[BIT_LOAD]) begin
                              if (ins_rd == REG_R15) begin
                                 next_psw[31:COND_LSB] = cfg[31:COND_LSB];
                              end else begin
                                 next_xfer = cfg;
                              end
                           end else if (ins_rd == REG_R15) begin
                              next_cfg = pc + PC_READ_OFS;
                           end else begin
                              next_cfg = xfer;
                           end
                        end
                     end else if (ins_class[3:1] == CLS_CMEM) begin
                        next_dec = ins & CMEM_MASK;
                        do_undef = 1'b1;
                     end else if (ins[COND_LSB-1:0] == RET_CODE) begin
                        next_pc      = link;
                        next_psw     = spsr;
                        next_outcome = OUT_RET;
                     end else begin
                        next_outcome = OUT_OTHER;
                     end
                     if (do_undef) begin
                        next_pc   = VEC_UNDEF;
                        next_psw  = psw;
                        next_psw[MODE_MSB:0] = MODE_UND;
                        next_undef   = 1'b1;
                        next_outcome = OUT_UNDEF;
                     end
                  end
                  default: next_pc = pc;
               endcase
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_cnt   = 3'h0;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state       <= ST_IDLE;
         cnt         <= 3'h0;
         pc          <= 32'h0000_0000;
         psw         <= PSW_RST;
         spsr        <= 32'h0000_0000;
         link        <= 32'h0000_0000;
         xfer        <= 32'h0000_0000;
         cfg         <= 32'h0000_0000;
         dec         <= 32'h0000_0000;
         outcome     <= OUT_NONE;
         soft_taken  <= 1'b0;
         undef_taken <= 1'b0;
      end else begin
         state       <= next_state;
         cnt         <= next_cnt;
         pc          <= next_pc;
         psw         <= next_psw;
         spsr        <= next_spsr;
         link        <= next_link;
         xfer        <= next_xfer;
         cfg         <= next_cfg;
         dec         <= next_dec;
         outcome     <= next_outcome;
         soft_taken  <= next_soft;
         undef_taken <= next_undef;
      end
   end

endmodule : sct_top

// ### testbench/sct_host_model.sv
module sct_host_model (
   // clock and answer
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   // request
   output logic             hsel,
   output logic [7:0]       haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   timeunit 1ns;
   timeprecision 100ps;
   logic hang = 1'b0;

   initial begin
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end

   // sampled at the falling edge so the flop update never races
   task automatic wait_ready(output logic [31:0] q);
      int n;
      logic r;
      n = 0;
      do begin
         @(negedge hclk);
         r = hready;
         q = hrdata;
         @(posedge hclk);
         n++;
      end while (!r && n < 64);
      if (!r) hang = 1'b1;
   endtask : wait_ready

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      wait_ready(q);
      htrans <= 2'b00;
      hwdata <= d;
      wait_ready(q);
      // stale data would hide a late sample
      hwdata <= ~d;
   endtask : xfer
endmodule : sct_host_model

// ### testbench/sct_properties.sv
module sct_properties
   import sct_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic              hclk,
   input wire logic              hresetn,
   // bus
   input wire logic              hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0]        htrans,
   input wire logic              hwrite,
   input wire logic [2:0]        hsize,
   input wire logic [31:0]       hwdata,
   input wire logic              hready,
   input wire logic              hreadyout,
   input wire logic [31:0]       hrdata,
   input wire logic              hresp,
   // events
   input wire logic              soft_taken,
   input wire logic              undef_taken,
   input wire logic              busy,
   input wire logic [31:0]       cur_status
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_soft_mode_svc:
      assert property (soft_taken |-> cur_status[4:0] == MODE_SVC)
         else $error("soft trap mode");
   a_soft_busy_len:
      assert property ($rose(busy) && soft_taken |-> busy[*2] ##1 !busy)
         else $error("soft trap length");
   a_cfg_busy_len:
      assert property ($rose(busy) && !soft_taken |-> busy[*3] ##1 !busy)
         else $error("config length");
   a_undef_mode:
      assert property (undef_taken |-> cur_status[4:0] == MODE_UND)
         else $error("undef mode");
   a_trap_excl:
      assert property (!(soft_taken && undef_taken)) else $error("two traps");
   a_soft_pulse:
      assert property (soft_taken |=> !soft_taken) else $error("soft trap pulse");
   a_undef_pulse:
      assert property (undef_taken |=> !undef_taken) else $error("undef pulse");
   // a read costs exactly one wait state
   a_read_wait:
      assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
         else $error("read wait");
   a_write_nowait:
      assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout && !hresp)
         else $error("write wait");
endmodule : sct_properties

bind sct_top sct_properties #(.ADDR_W(ADDR_W)) u_props (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .soft_taken(soft_taken),
   .undef_taken(undef_taken), .busy(busy), .cur_status(cur_status)
);

// ### testbench/tb_swi_coproc_trap_decode.sv
module tb_swi_coproc_trap_decode
   import sct_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        hclk = 1'b0;
   logic        hresetn;
   logic        hsel, hwrite, hreadyout, hresp, soft_taken, undef_taken, busy;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, cur_status;
   int          errors = 0;
   int          checks_done = 0;

   always #2.5 hclk = ~hclk;

   sct_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .soft_taken(soft_taken), .undef_taken(undef_taken), .busy(busy),
      .cur_status(cur_status));
   sct_host_model host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   always @(posedge hclk) if (host.hang) begin
      errors++;
      end_sim();
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] q;
      host.xfer(1'b0, a, 32'h0, q);
      chk(nm, exp, q);
   endtask : rchk

   // writes during busy are dropped, so wait it out
   task automatic exec(input logic [31:0] i, output logic sw, output logic ud, output int nb);
      logic [31:0] q;
      host.xfer(1'b1, OFS_INSTR, i, q);
      @(negedge hclk);
      sw = soft_taken;
      ud = undef_taken;
      nb = 0;
      while (busy === 1'b1 && nb < 20) begin
         nb++;
         @(negedge hclk);
      end
      if (nb >= 20) host.hang = 1'b1;
      @(posedge hclk);
   endtask : exec

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_soft();
      logic sw, ud;
      int nb;
      exec(32'hef12_3456, sw, ud, nb);
      chk("trap taken", 32'h1, 32'(sw));
      chk("trap busy", 32'h2, 32'(nb));
      rchk(OFS_PC, VEC_SOFT, "pc");
      rchk(OFS_SPSR, PSW_RST, "spsr");
      rchk(OFS_LINK, 32'h4, "link");
      rchk(OFS_PSW, 32'h13, "status");
      $display("test soft trap done");
   endtask : t_soft

   task automatic t_ret_nest();
      logic sw, ud;
      int nb;
      exec(32'he1b0_f00e, sw, ud, nb);
      rchk(OFS_PC, 32'h4, "ret pc");
      rchk(OFS_PSW, PSW_RST, "ret status");
      rchk(OFS_STAT, 32'ha, "ret stat");
      exec(32'hef00_0000, sw, ud, nb);
      exec(32'hef00_00ff, sw, ud, nb);
      rchk(OFS_LINK, 32'hc, "nest link");
      rchk(OFS_SPSR, 32'h13, "nest spsr");
      $display("test return nest done");
   endtask : t_ret_nest

   task automatic t_cond();
      logic sw, ud;
      int nb;
      // zero flag clear, so equal-condition fails
      exec(32'h0f00_0000, sw, ud, nb);
      chk("cond trap", 32'h0, 32'(sw));
      rchk(OFS_PC, 32'hc, "cond pc");
      rchk(OFS_PSW, 32'h13, "cond status");
      rchk(OFS_STAT, 32'h2, "cond stat");
      exec(32'h0e00_0000, sw, ud, nb);
      chk("cond undef", 32'h0, 32'(ud));
      $display("test cond done");
   endtask : t_cond

   task automatic t_cop();
      logic sw, ud;
      int nb;
      logic [31:0] tbl [4] = '{32'hee00_0000, 32'hed10_0000, 32'hee10_0110, 32'hecab_f3c7};
      foreach (tbl[k]) begin
         exec(tbl[k], sw, ud, nb);
         chk("undef", 32'h1, 32'(ud));
         rchk(OFS_PC, VEC_UNDEF, "undef pc");
         rchk(OFS_PSW, 32'h1b, "undef status");
      end
      // address side only, no data moved
      // length bit left in dec for the handler
      rchk(OFS_DEC, 32'h00a0_00c7, "dec");
      $display("test coproc done");
   endtask : t_cop

   task automatic t_cfg();
      logic sw, ud;
      int nb;
      logic [31:0] p, q;
      host.xfer(1'b1, OFS_XFER, 32'h5a5a_1234, q);
      exec(32'hee00_0f10, sw, ud, nb);
      chk("cfg busy", 32'h3, 32'(nb));
      rchk(OFS_CFG, 32'h5a5a_1234, "cfg");
      host.xfer(1'b0, OFS_PC, 32'h0, p);
      exec(32'hee10_ff10, sw, ud, nb);
      rchk(OFS_PSW, 32'h5000_001b, "flags");
      rchk(OFS_PC, p + 32'h4, "flags pc");
      exec(32'hee00_ff10, sw, ud, nb);
      rchk(OFS_CFG, p + WORD_STEP + PC_READ_OFS, "cfg from pc");
      rchk(8'h40, 32'h0, "unmapped");
      $display("test cfg done");
   endtask : t_cfg

   initial begin
      hresetn = 1'b0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      @(negedge hclk);
      chk("reset status", PSW_RST, cur_status);
      chk("reset idle", 32'h4, {29'h0, hreadyout, busy, hresp});
      @(posedge hclk);
      t_soft();
      t_ret_nest();
      t_cond();
      t_cop();
      t_cfg();
      end_sim();
   end
endmodule : tb_swi_coproc_trap_decode
